// ---- verilog/dpmc_pkg.sv ----
// Constants and types shared by the drive power mode controller files
package dpmc_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam int          ADDR_W      = 5;
    localparam int          DATA_W      = 32;
    localparam logic [4:0]  OFF_CMD     = 5'h00;
    localparam logic [4:0]  OFF_SECCNT  = 5'h04;
    localparam logic [4:0]  OFF_STATUS  = 5'h08;
    localparam logic [4:0]  OFF_COUNT   = 5'h0C;
    localparam logic [4:0]  OFF_ACCESS  = 5'h10;
    localparam logic [4:0]  OFF_CONTROL = 5'h14;

    // Status word fields
    localparam int ST_BUSY  = 0;
    localparam int ST_INTRQ = 1;
    localparam int ST_PWR   = 2;
    localparam int ST_APDEN = 4;
    localparam int ST_OWNER = 5;
    // Control word field
    localparam int CTL_SRST = 0;

    // ****************************************
    // Command codes and answers
    // ****************************************
    localparam logic [7:0] CMD_STBY_IMM = 8'hE0;
    localparam logic [7:0] CMD_IDLE_IMM = 8'hE1;
    localparam logic [7:0] CMD_STBY_APD = 8'hE2;
    localparam logic [7:0] CMD_IDLE_APD = 8'hE3;
    localparam logic [7:0] CMD_CHECK    = 8'hE5;
    localparam logic [7:0] CMD_SLEEP    = 8'hE6;
    localparam logic [7:0] SC_ALL_ONES  = 8'hFF;
    localparam logic [7:0] SC_ZERO      = 8'h00;
    localparam logic [7:0] SC_RESET     = 8'h00;

    // ****************************************
    // Timing
    // ****************************************
    localparam int          CLK_HZ         = 10_000_000;
    localparam int          UNIT_SECONDS   = 5;
    localparam int          TICK_CYCLES    = UNIT_SECONDS * CLK_HZ;
    localparam int          TMR_W          = 12;
    localparam logic [7:0]  HALF_HOUR_BASE = 8'hF0;
    localparam logic [7:0]  HALF_HOUR_LAST = 8'hFB;
    localparam logic [11:0] HALF_HOUR_UNIT = 12'h0168;
    localparam logic [11:0] TMR_RESET      = 12'h000;
    localparam logic [2:0]  BUSY_CYCLES    = 3'h4;

    typedef enum logic [1:0] {
        PWR_IDLE,
        PWR_STANDBY,
        PWR_SLEEP
    } dpmc_power_t;

    // Which command armed the countdown
    localparam logic OWNER_IDLE  = 1'b0;
    localparam logic OWNER_STBY  = 1'b1;

endpackage : dpmc_pkg

// ---- verilog/dpmc_tick_if.sv ----
// Link between the controller and its five-second tick generator
`timescale 1ns/1ps
interface dpmc_tick_if;
    logic run;
    logic clear;
    logic tick;
    modport ctl (output run, output clear, input tick);
    modport gen (input run, input clear, output tick);
endinterface : dpmc_tick_if

// ---- verilog/dpmc_tick_gen.sv ----
// Prescaler that turns the core clock into a one-cycle tick per timer unit
`timescale 1ns/1ps
module dpmc_tick_gen #(
    parameter int TICK_CYCLES = dpmc_pkg::TICK_CYCLES
) (
    input  wire logic   CLK_I,
    input  wire logic   NRST_I,
    dpmc_tick_if.gen    t
);
    localparam int CW = $clog2(TICK_CYCLES + 1);

    logic [CW-1:0] cnt;
    logic          tick;

    assign t.tick = tick;

    // Restarted on every reload so a fresh count always gets a full first unit
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (t.clear || !t.run) begin
            cnt  <= '0;
            tick <= 1'b0;
        end else if (cnt == CW'(TICK_CYCLES - 1)) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + CW'(1);
            tick <= 1'b0;
        end
    end

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    tick_run_a: assert property (tick |-> $past(t.run) && !$past(t.clear))
        else $error("tick raised while the timer was stopped");

endmodule : dpmc_tick_gen

// ---- verilog/dpmc_top.sv ----
// Drive power mode controller: power commands, countdown timer, motor enables
//
// Operation
// - Standby immediate enters standby, spindle unpowered, heads parked.
// - Idle immediate enters idle without waiting for the countdown.
// - Standby with countdown enters standby, then samples sector count.
// - Idle with countdown enters idle, then samples sector count.
// - Nonzero count arms countdown; zero disarms, standby variant still enters standby.
// - Count is in five-second units; host supplies 12 to 255.
// - Counts 241 to 251 mean 30-minute steps, 30 min to 5.5 hours.
// - Every drive access reloads the countdown with the captured value.
// - Completion of any command reloads the countdown.
// - Countdown reaching zero enters standby, whichever command armed it.
// - One timer for both; only the arming command may disarm it.
// - Standby or idle timer setting persists until the other is issued.
// - Sleep and both immediate commands are one-shot, timer setting unchanged.
// - Media command wakes from standby; standby returns at next expiry.
// - Standby and sleep keep spindle and actuator off, heads parked.
// - Sleep command enters sleep; a reset moves sleep to standby.
// - Check power mode writes all ones when idle, zero otherwise.
// - After reset the timer setting defaults to the idle command.
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
module dpmc_top
    import dpmc_pkg::*;
#(
    parameter int TICK_CYCLES = dpmc_pkg::TICK_CYCLES
) (
    input  wire logic                         CLK_I,
    input  wire logic                         NRST_I,
    input  wire logic [dpmc_pkg::ADDR_W-1:0]  AVS_ADDRESS_I,
    input  wire logic                         AVS_READ_I,
    input  wire logic                         AVS_WRITE_I,
    input  wire logic [dpmc_pkg::DATA_W-1:0]  AVS_WRITEDATA_I,
    output logic      [dpmc_pkg::DATA_W-1:0]  AVS_READDATA_O,
    output logic                              AVS_WAITREQUEST_O,
    output logic                              SPINDLE_EN_O,
    output logic                              ACTUATOR_EN_O,
    output logic                              HEADS_PARKED_O,
    output logic                              BUSY_O,
    output logic                              INTRQ_O
);
    import dpmc_pkg::*;

    // ****************************************
    // Helpers
    // ****************************************
    // Sector count value to timer units
    function automatic logic [TMR_W-1:0] units_of(input logic [7:0] sc);
        logic [TMR_W-1:0] steps;
        steps = TMR_W'(sc - HALF_HOUR_BASE);
        if (sc > HALF_HOUR_BASE && sc <= HALF_HOUR_LAST) begin
            units_of = TMR_W'(steps * HALF_HOUR_UNIT);
        end else begin
            units_of = TMR_W'(sc);
        end
    endfunction : units_of

    // Owner code of the arming command
    function automatic logic owner_of(input logic [7:0] cmd);
        owner_of = (cmd == CMD_STBY_APD) ? OWNER_STBY : OWNER_IDLE;
    endfunction : owner_of

    // ****************************************
    // Declarations
    // ****************************************
    dpmc_power_t      pwr;
    dpmc_power_t      next_pwr;
    logic [7:0]       seccnt;
    logic [TMR_W-1:0] count;
    logic [TMR_W-1:0] apd_reload;
    logic             apd_en;
    logic             apd_owner;
    logic [2:0]       busy_cnt;
    logic             take;
    logic             cmd_wr;
    logic             cmd_go;
    logic             cmd_done;
    logic             access_wr;
    logic             srst_wr;
    logic             status_rd;
    logic [7:0]       code;
    logic             is_power_cmd;
    logic             apd_cfg;
    logic             expire;
    logic [DATA_W-1:0] next_rdata;

    dpmc_tick_if tick_bus ();

    dpmc_tick_gen #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .CLK_I  (CLK_I),
        .NRST_I (NRST_I),
        .t      (tick_bus.gen)
    );

    // ****************************************
    // Avalon-MM slave
    // ****************************************
    // One wait cycle per access; the request is taken on the edge where
    // waitrequest is seen low, read data already standing there.
    assign take      = (AVS_READ_I || AVS_WRITE_I) && !AVS_WAITREQUEST_O;
    assign code      = AVS_WRITEDATA_I[7:0];
    assign cmd_wr    = take && AVS_WRITE_I && AVS_ADDRESS_I == OFF_CMD;
    assign cmd_go    = cmd_wr && !BUSY_O;
    assign access_wr = take && AVS_WRITE_I && AVS_ADDRESS_I == OFF_ACCESS;
    assign srst_wr   = take && AVS_WRITE_I && AVS_ADDRESS_I == OFF_CONTROL && AVS_WRITEDATA_I[CTL_SRST];
    assign status_rd = take && AVS_READ_I && AVS_ADDRESS_I == OFF_STATUS;

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            AVS_WAITREQUEST_O <= 1'b1;
        end else begin
            AVS_WAITREQUEST_O <= !((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O);
        end
    end

    always_comb begin
        next_rdata = '0;
        if (AVS_ADDRESS_I == OFF_SECCNT) begin
            next_rdata[7:0] = seccnt;
        end else if (AVS_ADDRESS_I == OFF_STATUS) begin
            next_rdata[ST_BUSY]        = BUSY_O;
            next_rdata[ST_INTRQ]       = INTRQ_O;
            next_rdata[ST_PWR +: 2]    = pwr;
            next_rdata[ST_APDEN]       = apd_en;
            next_rdata[ST_OWNER]       = apd_owner;
        end else if (AVS_ADDRESS_I == OFF_COUNT) begin
            next_rdata[TMR_W-1:0] = count;
        end else begin
            next_rdata = '0;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            AVS_READDATA_O <= '0;
        end else if (AVS_READ_I && AVS_WAITREQUEST_O) begin
            AVS_READDATA_O <= next_rdata;
        end
    end

    // ****************************************
    // Command execution and busy
    // ****************************************
    assign is_power_cmd = code == CMD_STBY_IMM || code == CMD_IDLE_IMM || code == CMD_STBY_APD
                       || code == CMD_IDLE_APD || code == CMD_CHECK || code == CMD_SLEEP;
    assign apd_cfg      = cmd_go && (code == CMD_STBY_APD || code == CMD_IDLE_APD);
    assign cmd_done     = BUSY_O && busy_cnt == 3'h1;

    // A command written while busy is dropped; the host must wait for completion
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            BUSY_O   <= 1'b0;
            busy_cnt <= 3'h0;
        end else if (cmd_go) begin
            BUSY_O   <= 1'b1;
            busy_cnt <= BUSY_CYCLES;
        end else if (cmd_done) begin
            BUSY_O   <= 1'b0;
            busy_cnt <= 3'h0;
        end else if (BUSY_O) begin
            busy_cnt <= busy_cnt - 3'h1;
        end
    end

    // Completion wins over a status read in the same cycle
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            INTRQ_O <= 1'b0;
        end else if (cmd_done) begin
            INTRQ_O <= 1'b1;
        end else if (status_rd || cmd_go) begin
            INTRQ_O <= 1'b0;
        end
    end

    // Sector count: host writes, check power mode overwrites
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            seccnt <= SC_RESET;
        end else if (cmd_go && code == CMD_CHECK) begin
            seccnt <= (pwr == PWR_IDLE) ? SC_ALL_ONES : SC_ZERO;
        end else if (take && AVS_WRITE_I && AVS_ADDRESS_I == OFF_SECCNT) begin
            seccnt <= AVS_WRITEDATA_I[7:0];
        end
    end

    // ****************************************
    // Countdown arming
    // ****************************************
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            apd_en     <= 1'b0;
            apd_owner  <= OWNER_IDLE;
            apd_reload <= TMR_RESET;
        end else if (srst_wr) begin
            apd_en     <= 1'b0;
            apd_owner  <= OWNER_IDLE;
        end else if (apd_cfg) begin
            if (seccnt != SC_ZERO) begin
                apd_en     <= 1'b1;
                apd_owner  <= owner_of(code);
                apd_reload <= units_of(seccnt);
            end else if (apd_owner == owner_of(code)) begin
                apd_en     <= 1'b0;
            end
            // A zero from the other command leaves the arming untouched
        end
    end

    // ****************************************
    // Countdown timer
    // ****************************************
    assign tick_bus.run   = apd_en && count != TMR_RESET;
    assign tick_bus.clear = access_wr || cmd_done || apd_cfg;
    assign expire         = apd_en && tick_bus.tick && count == TMR_W'(1);

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            count <= TMR_RESET;
        end else if (apd_cfg && seccnt != SC_ZERO) begin
            count <= units_of(seccnt);
        end else if (access_wr || cmd_done) begin
            count <= apd_reload;
        end else if (tick_bus.run && tick_bus.tick) begin
            count <= count - TMR_W'(1);
        end
    end

    // ****************************************
    // Power state
    // ****************************************
    always_comb begin
        next_pwr = pwr;
        if (srst_wr && pwr == PWR_SLEEP) begin
            next_pwr = PWR_STANDBY;
        end else if (cmd_go) begin
            case (code)
                CMD_STBY_IMM: next_pwr = PWR_STANDBY;
                CMD_IDLE_IMM: next_pwr = PWR_IDLE;
                CMD_STBY_APD: next_pwr = PWR_STANDBY;
                CMD_IDLE_APD: next_pwr = PWR_IDLE;
                CMD_SLEEP:    next_pwr = PWR_SLEEP;
                CMD_CHECK:    next_pwr = pwr;
                default: begin
                    // A sleeping drive waits for a reset first
                    if (pwr == PWR_STANDBY) begin
                        next_pwr = PWR_IDLE;
                    end
                end
            endcase
        end else if (access_wr && pwr == PWR_STANDBY) begin
            next_pwr = PWR_IDLE;
        end else if (expire && pwr == PWR_IDLE) begin
            next_pwr = PWR_STANDBY;
        end
    end

    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            pwr <= PWR_STANDBY;
        end else begin
            pwr <= next_pwr;
        end
    end

    // Motors follow the state in the same cycle as the state register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SPINDLE_EN_O   <= 1'b0;
            ACTUATOR_EN_O  <= 1'b0;
            HEADS_PARKED_O <= 1'b1;
        end else begin
            SPINDLE_EN_O   <= next_pwr == PWR_IDLE;
            ACTUATOR_EN_O  <= next_pwr == PWR_IDLE;
            HEADS_PARKED_O <= next_pwr != PWR_IDLE;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    busy_length_a: assert property (cmd_go |=> BUSY_O [*4] ##1 !BUSY_O)
        else $error("busy did not last four cycles");
    done_irq_a: assert property ($fell(BUSY_O) |-> INTRQ_O)
        else $error("no interrupt at command completion");
    standby_imm_a: assert property (cmd_go && code == CMD_STBY_IMM |=> pwr == PWR_STANDBY && HEADS_PARKED_O)
        else $error("standby immediate did not park");
    idle_imm_a: assert property (cmd_go && code == CMD_IDLE_IMM |=> pwr == PWR_IDLE && SPINDLE_EN_O)
        else $error("idle immediate did not reach idle");
    sleep_enter_a: assert property (cmd_go && code == CMD_SLEEP |=> pwr == PWR_SLEEP)
        else $error("sleep command ignored");
    check_idle_a: assert property (cmd_go && code == CMD_CHECK && pwr == PWR_IDLE |=> seccnt == SC_ALL_ONES)
        else $error("check power mode wrong while idle");
    check_stby_a: assert property (cmd_go && code == CMD_CHECK && pwr != PWR_IDLE |=> seccnt == SC_ZERO)
        else $error("check power mode wrong while not idle");
    expire_stby_a: assert property (expire && !cmd_go && !access_wr && !srst_wr |=> pwr != PWR_IDLE)
        else $error("expiry did not leave idle");
    access_reload_a: assert property (access_wr && !apd_cfg |=> count == $past(apd_reload))
        else $error("access did not reload countdown");
    zero_disarm_a: assert property (apd_cfg && seccnt == SC_ZERO && apd_owner == OWNER_STBY
                                    && code == CMD_IDLE_APD |=> apd_en == $past(apd_en))
        else $error("other command changed the arming");
    motors_off_a: assert property (pwr != PWR_IDLE |-> !SPINDLE_EN_O && !ACTUATOR_EN_O)
        else $error("motor on outside idle");
    bus_answer_a: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("waitrequest held too long");
    busy_drop_a: assert property (cmd_wr && BUSY_O && busy_cnt != 3'h1
                                  |=> BUSY_O && busy_cnt == $past(busy_cnt) - 3'h1)
        else $error("command written while busy restarted the countdown of busy");

    // Countdown and power state checks
    stby_zero_a: assert property (cmd_go && code == CMD_STBY_APD && seccnt == SC_ZERO |=> pwr == PWR_STANDBY)
        else $error("standby with zero count did not enter standby");
    arm_load_a: assert property (apd_cfg && seccnt != SC_ZERO |=> apd_en && count == apd_reload)
        else $error("nonzero count did not arm the countdown");
    half_hour_a: assert property (apd_cfg && seccnt == HALF_HOUR_BASE + 8'h01 |=> count == HALF_HOUR_UNIT)
        else $error("first half hour step loaded the wrong count");
    done_reload_a: assert property (cmd_done |=> count == $past(apd_reload))
        else $error("completion did not reload countdown");
    tick_step_a: assert property (tick_bus.run && tick_bus.tick && !apd_cfg && !access_wr && !cmd_done
                                  |=> count == $past(count) - TMR_W'(1))
        else $error("countdown did not step once per tick");
    one_shot_a: assert property (cmd_go && (code == CMD_SLEEP || code == CMD_STBY_IMM
                                 || code == CMD_IDLE_IMM) |=> apd_en == $past(apd_en)
                                 && apd_owner == $past(apd_owner))
        else $error("one-shot command changed the timer setting");
    sleep_wake_a: assert property (srst_wr && pwr == PWR_SLEEP |=> pwr == PWR_STANDBY && HEADS_PARKED_O)
        else $error("reset did not move sleep to standby");
    media_wake_a: assert property (cmd_go && !is_power_cmd && pwr == PWR_STANDBY |=> pwr == PWR_IDLE && SPINDLE_EN_O)
        else $error("media command did not wake from standby");

    expiry_c: cover property (expire && pwr == PWR_IDLE);
    wake_c: cover property (pwr == PWR_STANDBY ##1 pwr == PWR_IDLE);
    sleep_reset_c: cover property (pwr == PWR_SLEEP ##1 pwr == PWR_STANDBY);
    check_c: cover property (cmd_go && code == CMD_CHECK);
    drop_c: cover property (cmd_wr && BUSY_O);

endmodule : dpmc_top

// ---- verification/dpmc_host_model.sv ----
// Host adapter model: Avalon-MM master issuing task-register accesses
`timescale 1ns/1ps
module dpmc_host_model
    import dpmc_pkg::*;
(
    input  wire logic                         CLK_I,
    input  wire logic                         AVS_WAITREQUEST_I,
    input  wire logic [dpmc_pkg::DATA_W-1:0]  AVS_READDATA_I,
    output logic      [dpmc_pkg::ADDR_W-1:0]  AVS_ADDRESS_O,
    output logic                              AVS_READ_O,
    output logic                              AVS_WRITE_O,
    output logic      [dpmc_pkg::DATA_W-1:0]  AVS_WRITEDATA_O
);
    int gap_max = 3;
    initial begin
        AVS_ADDRESS_O   = '0;
        AVS_READ_O      = 1'b0;
        AVS_WRITE_O     = 1'b0;
        AVS_WRITEDATA_O = '0;
    end
    // ****************************************
    // Bus cycles
    // ****************************************
    task automatic access(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        repeat ($urandom % gap_max) @(posedge CLK_I);
        @(posedge CLK_I);
        AVS_ADDRESS_O   <= a;
        AVS_WRITEDATA_O <= d;
        AVS_READ_O      <= ~wr;
        AVS_WRITE_O     <= wr;
        do @(posedge CLK_I); while (AVS_WAITREQUEST_I !== 1'b0);
        q = AVS_READDATA_I;
        AVS_READ_O  <= 1'b0;
        AVS_WRITE_O <= 1'b0;
        // Released lines flip so a stale value is never mistaken for a held one
        AVS_ADDRESS_O   <= ~a;
        AVS_WRITEDATA_O <= ~d;
    endtask : access
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] q;
        access(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        access(1'b0, a, 32'h0000_0000, q);
    endtask : rd
    task automatic issue(input logic [7:0] code, input logic [7:0] sc);
        wr(OFF_SECCNT, {24'h00_0000, sc});
        wr(OFF_CMD, {24'h00_0000, code});
    endtask : issue
    // Moves sleep to standby; a media command alone does not leave sleep
    task automatic soft_reset();
        wr(OFF_CONTROL, 32'h0000_0001);
    endtask : soft_reset
endmodule : dpmc_host_model

// ---- verification/drive_power_mode_control_test.sv ----
// Self-checking bench for the drive power mode controller
`timescale 1ns/1ps
module drive_power_mode_control_test;
    import dpmc_pkg::*;
    typedef struct {logic [31:0] lo; logic [31:0] hi; logic [31:0] mask;} dpmc_note_t;
    localparam logic [31:0] SM = 32'h0000_003F;
    localparam logic [31:0] AM = 32'h0000_0010;
    localparam logic [7:0]  CODES [6] = '{8'hE1, 8'hE5, 8'hE0, 8'hE5, 8'hE6, 8'hE5};
    localparam logic [1:0]  PW [6]    = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic        clk, rst_n, rd_s, wr_s, wait_s, spin, act, park, busy, irq;
    logic [4:0]  addr;
    logic [31:0] wdata, rdata, q;
    logic [7:0]  n8;
    logic [31:0] e;
    dpmc_note_t  notes [$];
    dpmc_note_t  cur;
    int          errors = 0;
    int          checks_done = 0;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    dpmc_top #(.TICK_CYCLES(10)) i_dut (.CLK_I(clk), .NRST_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_s),
        .AVS_WRITE_I(wr_s), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_s),
        .SPINDLE_EN_O(spin), .ACTUATOR_EN_O(act), .HEADS_PARKED_O(park), .BUSY_O(busy), .INTRQ_O(irq));
    dpmc_host_model i_host (.CLK_I(clk), .AVS_WAITREQUEST_I(wait_s), .AVS_READDATA_I(rdata),
        .AVS_ADDRESS_O(addr), .AVS_READ_O(rd_s), .AVS_WRITE_O(wr_s), .AVS_WRITEDATA_O(wdata));

    // ****************************************
    // Comparison and bookkeeping
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] lo, input logic [31:0] hi);
        checks_done++;
        if (((seen >= lo) && (seen <= hi)) !== 1'b1) begin
            errors++;
            $display("BAD %s expected %0h..%0h seen %0h", what, lo, hi, seen);
        end
    endtask : check
    task automatic stop_test();
        $display("Checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    function automatic logic [31:0] st(input logic i, input logic [1:0] p, input logic en, input logic own);
        st = 32'h0000_0000;
        st[ST_INTRQ]    = i;
        st[ST_PWR +: 2] = p;
        st[ST_APDEN]    = en;
        st[ST_OWNER]    = own;
    endfunction : st
    task automatic xrd(input logic [4:0] a, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] m);
        notes.push_back('{lo, hi, m});
        i_host.rd(a, q);
    endtask : xrd
    // Read data is judged where it is taken, against the oldest note
    always @(posedge clk) begin
        if (rd_s === 1'b1 && wait_s === 1'b0) begin
            if (notes.size() == 0) begin
                errors++;
                $display("BAD read expected none seen %0h", rdata);
            end else begin
                cur = notes.pop_front();
                check("read data", rdata & cur.mask, cur.lo, cur.hi);
            end
        end
    end
    task automatic cmd(input logic [7:0] code, input logic [7:0] sc);
        int n;
        i_host.issue(code, sc);
        #1;
        n = 0;
        while (busy === 1'b1 && n < 20) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("busy cycles", n, BUSY_CYCLES, BUSY_CYCLES);
        check("intrq", irq, 1, 1);
    endtask : cmd
    task automatic motors(input logic on);
        check("spindle", spin, on, on);
        check("actuator", act, on, on);
        check("parked", park, !on, !on);
    endtask : motors
    task automatic wait_park(input int lim);
        int n;
        n = 0;
        while (park !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_park

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        #(20_000 * 100);
        errors++;
        $display("BAD watchdog expected done seen timeout");
        stop_test();
    end
    initial begin
        void'($urandom(4539));
        rst_n = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        xrd(OFF_STATUS, st(0, 1, 0, 0), st(0, 1, 0, 0), SM);
        motors(1'b0);
        xrd(OFF_SECCNT, 0, 0, 32'hFFFF_FFFF);
        xrd(5'h18, 0, 0, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++) begin
            cmd(CODES[i], 8'h00);
            xrd(OFF_STATUS, st(1, PW[i], 0, 0), st(1, PW[i], 0, 0), SM);
            xrd(OFF_STATUS, st(0, PW[i], 0, 0), st(0, PW[i], 0, 0), SM);
            motors(PW[i] == 2'h0);
            e = (PW[i] == 2'h0) ? SC_ALL_ONES : SC_ZERO;
            if (CODES[i] == CMD_CHECK) xrd(OFF_SECCNT, e, e, 32'h0000_00FF);
        end
        i_host.soft_reset();
        xrd(OFF_STATUS, st(0, 1, 0, 0), st(0, 1, 0, 0), SM);
        cmd(8'h20, 8'h00);
        xrd(OFF_STATUS, st(1, 0, 0, 0), st(1, 0, 0, 0), SM);
        cmd(CMD_IDLE_APD, 8'd12);
        xrd(OFF_STATUS, st(1, 0, 1, 0), st(1, 0, 1, 0), SM);
        xrd(OFF_COUNT, 11, 12, 32'h0000_0FFF);
        repeat (60) @(posedge clk);
        i_host.wr(OFF_ACCESS, 32'h0000_0000);
        repeat (100) @(posedge clk);
        #1;
        check("spindle", spin, 1, 1);
        wait_park(60);
        check("parked", park, 1, 1);
        xrd(OFF_STATUS, st(0, 1, 1, 0), st(0, 1, 1, 0), SM);
        xrd(OFF_COUNT, 0, 0, 32'h0000_0FFF);
        i_host.wr(OFF_ACCESS, 32'h0000_0000);
        repeat (2) @(posedge clk);
        #1;
        check("spindle", spin, 1, 1);
        wait_park(150);
        check("parked", park, 1, 1);
        cmd(CMD_STBY_APD, 8'd241);
        xrd(OFF_STATUS, st(1, 1, 1, 1), st(1, 1, 1, 1), SM);
        xrd(OFF_COUNT, 359, 360, 32'h0000_0FFF);
        cmd(CMD_IDLE_IMM, 8'h00);
        xrd(OFF_STATUS, st(1, 0, 1, 1), st(1, 0, 1, 1), SM);
        xrd(OFF_COUNT, 359, 360, 32'h0000_0FFF);
        cmd(CMD_IDLE_APD, 8'h00);
        xrd(OFF_STATUS, AM, AM, AM);
        cmd(CMD_STBY_APD, 8'h00);
        xrd(OFF_STATUS, st(1, 1, 0, 1), st(1, 1, 0, 1), SM);
        repeat (4) begin
            n8 = 8'd12 + 8'($urandom % 229);
            cmd(CMD_IDLE_APD, n8);
            xrd(OFF_COUNT, n8 - 1, n8, 32'h0000_0FFF);
            n8 = 8'd241 + 8'($urandom % 11);
            cmd(CMD_STBY_APD, n8);
            e = (n8 - 240) * 360;
            xrd(OFF_COUNT, e - 1, e, 32'h0000_0FFF);
        end
        i_host.gap_max = 1;
        i_host.wr(OFF_CMD, {24'h00_0000, CMD_IDLE_IMM});
        i_host.wr(OFF_CMD, {24'h00_0000, CMD_SLEEP});
        i_host.gap_max = 3;
        repeat (6) @(posedge clk);
        xrd(OFF_STATUS, st(1, 0, 1, 1), st(1, 0, 1, 1), SM);
        cmd(CMD_IDLE_APD, 8'd20);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        xrd(OFF_STATUS, st(0, 1, 0, 0), st(0, 1, 0, 0), SM);
        motors(1'b0);
        stop_test();
    end
endmodule : drive_power_mode_control_test
